// [rtl/fcpd_cfg.svh]
// constant definitions for the floppy command phase decoder
`ifndef FCPD_CFG_SVH
`define FCPD_CFG_SVH
`define FCPD_OP_WRITE      5'h05
`define FCPD_OP_WDEL       5'h09
`define FCPD_OP_FORMAT     6'h0D
`define FCPD_OP_RECAL      8'h07
`define FCPD_OP_SENSE      8'h08
`define FCPD_OP_SPECIFY    8'h03
`define FCPD_OP_SEEK       8'h0F
`define FCPD_OP_CONFIG     8'h13
`define FCPD_ST0_INVALID   8'h80
`define FCPD_ST0_SEEK_END  8'h20
`define FCPD_NPRM_RW       4'h8
`define FCPD_NPRM_FORMAT   4'h5
`define FCPD_NPRM_RECAL    4'h1
`define FCPD_NPRM_SPECIFY  4'h2
`define FCPD_NPRM_SEEK     4'h2
`define FCPD_NPRM_CONFIG   4'h3
`define FCPD_NRES_RW       3'h7
`define FCPD_NRES_SENSE    3'h2
`define FCPD_NRES_INVALID  3'h1
`define FCPD_FIFO_DEPTH    32
`endif

// [rtl/fcpd_pkg.sv]
// types shared by the floppy command phase decoder files
package fcpd_pkg;
  typedef enum logic [3:0] {
    FCPD_K_WRITE, FCPD_K_WDEL, FCPD_K_FORMAT, FCPD_K_RECAL, FCPD_K_SENSE,
    FCPD_K_SPECIFY, FCPD_K_SEEK, FCPD_K_CONFIG, FCPD_K_INVALID
  } fcpd_kind_t;

  // execution request toward the drive-side logic
  typedef struct packed {
    fcpd_kind_t kind;
    logic       multi_track;
    logic       double_density;
    logic       head_select;
    logic [1:0] drive_select;
    logic [7:0] cylinder;
    logic [7:0] head;
    logic [7:0] record;
    logic [7:0] size_code;
    logic [7:0] final_sector_number;
    logic [7:0] gap_length;
    logic [7:0] data_length;
    logic [7:0] sectors_per_track;
    logic [7:0] filler;
  } fcpd_exec_t;

  // completion report from the drive-side logic
  typedef struct packed {
    logic [7:0] status_byte_zero;
    logic [7:0] status_byte_one;
    logic [7:0] status_byte_two;
    logic [7:0] cylinder;
    logic [7:0] head;
    logic [7:0] record;
    logic [7:0] size_code;
  } fcpd_done_t;

  // timing and option settings held from specify and configure
  typedef struct packed {
    logic [3:0] step_rate_time;
    logic [3:0] head_unload_time;
    logic [6:0] head_load_time;
    logic       pio_transfer_flag;
    logic       implied_seek_enable;
    logic       queue_disable;
    logic       poll_disable;
    logic [3:0] queue_threshold;
    logic [7:0] precomp_start_cylinder;
  } fcpd_setup_t;
endpackage

// [rtl/fcpd_fifo.sv]
// synchronous valid/ready fifo for the execution data path
`timescale 1ns/10ps
module fcpd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // full and empty come straight from the occupancy count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // storage array
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [rtl/fcpd_top.sv]
// command phase decoder for write, format, positioning and setup commands
//
// What this block does
// - low bits 00101 decode as write data
// - low bits 01001 decode as write deleted
// - writes return status zero, one, two, C,H,R,N
// - 0x07 recalibrates to cylinder zero, interrupt only
// - 0x08 returns status zero and present cylinder
// - 0x0F seeks to target cylinder, no results
// - unknown opcode returns single 0x80 status byte
`timescale 1ns/10ps
`include "fcpd_cfg.svh"
module fcpd_top
  import fcpd_pkg::*;
#(
  parameter int FIFO_DEPTH = `FCPD_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // host bytes written to the data port
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  // result bytes read from the data port
  output logic             res_valid,
  output logic [7:0]       res_data,
  input  wire logic        res_ready,
  // execution request and completion from drive-side logic
  output logic             exec_start,
  output fcpd_exec_t       exec_cmd,
  input  wire logic        exec_done,
  input  wire fcpd_done_t  exec_report,
  // execution data stream toward the drive
  output logic             drv_valid,
  output logic [7:0]       drv_data,
  input  wire logic        drv_ready,
  // completion interrupt and stored settings
  output logic             done_irq,
  output fcpd_setup_t      setup,
  output logic             busy
);
  typedef enum {ST_IDLE, ST_PARAM, ST_EXEC, ST_RESULT} fcpd_state_t;

  fcpd_state_t state;
  fcpd_kind_t  kind;
  logic [7:0]  opcode;
  logic [7:0]  prm [8];
  logic [3:0]  prm_idx;
  logic [3:0]  prm_need;
  logic [7:0]  res [7];
  logic [2:0]  res_idx;
  logic [2:0]  res_cnt;
  logic [9:0]  id_left;
  logic [7:0]  present_cylinder [4];
  logic        int_pend;
  logic [7:0]  int_st0;
  logic [1:0]  int_drive;

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode of the first byte
  wire        is_write  = (cmd_data[4:0] == `FCPD_OP_WRITE);
  wire        is_wdel   = (cmd_data[4:0] == `FCPD_OP_WDEL);
  wire        is_format = (cmd_data[5:0] == `FCPD_OP_FORMAT) && !cmd_data[7];
  wire        is_recal  = (cmd_data == `FCPD_OP_RECAL);
  wire        is_sense  = (cmd_data == `FCPD_OP_SENSE);
  wire        is_spec   = (cmd_data == `FCPD_OP_SPECIFY);
  wire        is_seek   = (cmd_data == `FCPD_OP_SEEK);
  wire        is_config = (cmd_data == `FCPD_OP_CONFIG);
  fcpd_kind_t dec_kind;
  assign dec_kind = is_write  ? FCPD_K_WRITE  : is_wdel  ? FCPD_K_WDEL   :
                    is_format ? FCPD_K_FORMAT : is_recal ? FCPD_K_RECAL  :
                    is_sense  ? FCPD_K_SENSE  : is_spec  ? FCPD_K_SPECIFY :
                    is_seek   ? FCPD_K_SEEK   : is_config ? FCPD_K_CONFIG :
                    FCPD_K_INVALID;
  wire [3:0] dec_need = (is_write || is_wdel) ? `FCPD_NPRM_RW :
                        is_format ? `FCPD_NPRM_FORMAT :
                        is_recal  ? `FCPD_NPRM_RECAL :
                        is_spec   ? `FCPD_NPRM_SPECIFY :
                        is_seek   ? `FCPD_NPRM_SEEK :
                        is_config ? `FCPD_NPRM_CONFIG : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // execution request fields taken from the parameter bytes
  wire [1:0] sel_drive = prm[0][1:0];
  assign exec_cmd.kind                = kind;
  assign exec_cmd.multi_track         = opcode[7];
  assign exec_cmd.double_density      = opcode[6];
  assign exec_cmd.head_select         = (kind == FCPD_K_RECAL) ? 1'b0 : prm[0][2];
  assign exec_cmd.drive_select        = sel_drive;
  assign exec_cmd.cylinder            = (kind == FCPD_K_RECAL) ? 8'h00 : prm[1];
  assign exec_cmd.head                = prm[2];
  assign exec_cmd.record              = prm[3];
  assign exec_cmd.size_code           = (kind == FCPD_K_FORMAT) ? prm[1] : prm[4];
  assign exec_cmd.final_sector_number = prm[5];
  assign exec_cmd.gap_length          = (kind == FCPD_K_FORMAT) ? prm[3] : prm[6];
  assign exec_cmd.data_length         = prm[7];
  assign exec_cmd.sectors_per_track   = prm[2];
  assign exec_cmd.filler              = prm[4];

  ////////////////////////////////////////////////////////////////////////////
  // host byte acceptance and the data stream into the fifo
  logic fifo_in_ready;
  wire  streaming = (state == ST_EXEC) && (kind != FCPD_K_RECAL) && (kind != FCPD_K_SEEK)
                    && !((kind == FCPD_K_FORMAT) && (id_left == 10'h000));
  wire  prm_phase = (state == ST_IDLE) || (state == ST_PARAM);
  assign cmd_ready = prm_phase || (streaming && fifo_in_ready);
  wire  cmd_take  = cmd_valid && cmd_ready;
  wire  to_fifo   = cmd_take && streaming;
  wire  res_take  = res_valid && res_ready;
  assign res_valid = (state == ST_RESULT);
  assign busy      = (state != ST_IDLE);

  fcpd_fifo #(
    .WIDTH     (8),
    .DEPTH     (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (to_fifo),
    .in_data   (cmd_data),
    .in_ready  (fifo_in_ready),
    .out_valid (drv_valid),
    .out_data  (drv_data),
    .out_ready (drv_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state      <= ST_IDLE;
      kind       <= FCPD_K_INVALID;
      opcode     <= 8'h00;
      prm_idx    <= 4'h0;
      prm_need   <= 4'h0;
      exec_start <= 1'b0;
      id_left    <= 10'h000;
      res_idx    <= 3'h0;
      res_cnt    <= 3'h0;
    end else begin
      exec_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_take) begin
            opcode   <= cmd_data;
            kind     <= dec_kind;
            prm_need <= dec_need;
            prm_idx  <= 4'h0;
            res_idx  <= 3'h0;
            if (dec_kind == FCPD_K_SENSE) begin
              res_cnt <= `FCPD_NRES_SENSE;
              state   <= ST_RESULT;
            end else if (dec_kind == FCPD_K_INVALID) begin
              res_cnt <= `FCPD_NRES_INVALID;
              state   <= ST_RESULT;
            end else begin
              state <= ST_PARAM;
            end
          end
        end
        ST_PARAM: begin
          if (cmd_take && (prm_idx == prm_need - 4'h1)) begin
            if ((kind == FCPD_K_SPECIFY) || (kind == FCPD_K_CONFIG)) begin
              state <= ST_IDLE;
            end else begin
              exec_start <= 1'b1;
              id_left    <= {prm[2], 2'b00};
              state      <= ST_EXEC;
            end
          end
          if (cmd_take) begin
            prm_idx <= prm_idx + 4'h1;
          end
        end
        ST_EXEC: begin
          if (to_fifo && (kind == FCPD_K_FORMAT)) begin
            id_left <= id_left - 10'h001;
          end
          if (exec_done) begin
            res_cnt <= `FCPD_NRES_RW;
            state   <= ((kind == FCPD_K_RECAL) || (kind == FCPD_K_SEEK)) ?
                       ST_IDLE : ST_RESULT;
          end
        end
        ST_RESULT: begin
          if (res_take) begin
            res_idx <= res_idx + 3'h1;
            if (res_idx == res_cnt - 3'h1) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter byte capture
  always_ff @(posedge mclk) begin
    if (state == ST_PARAM && cmd_take) begin
      prm[prm_idx[2:0]] <= cmd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result bytes, loaded when the result phase is entered
  wire [7:0] sense_st0 = int_pend ? int_st0 : `FCPD_ST0_INVALID;
  wire       fmt       = (kind == FCPD_K_FORMAT);
  always_ff @(posedge mclk) begin
    if (state == ST_IDLE && cmd_take) begin
      res[0] <= is_sense ? sense_st0 : `FCPD_ST0_INVALID;
      res[1] <= present_cylinder[int_drive];
    end else if (state == ST_EXEC && exec_done) begin
      res[0] <= exec_report.status_byte_zero;
      res[1] <= exec_report.status_byte_one;
      res[2] <= exec_report.status_byte_two;
      res[3] <= fmt ? 8'h00 : exec_report.cylinder;
      res[4] <= fmt ? 8'h00 : exec_report.head;
      res[5] <= fmt ? 8'h00 : exec_report.record;
      res[6] <= fmt ? 8'h00 : exec_report.size_code;
    end
  end

  // registered data output follows the result index
  always_ff @(posedge mclk) begin
    if (rst) begin
      res_data <= 8'h00;
    end else if (state == ST_IDLE && cmd_take) begin
      res_data <= is_sense ? sense_st0 : `FCPD_ST0_INVALID;
    end else if (state == ST_EXEC && exec_done) begin
      res_data <= exec_report.status_byte_zero;
    end else if (res_take && (res_idx != 3'h6)) begin
      res_data <= res[res_idx + 3'h1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // present cylinder per drive and positioning interrupt
  wire pos_done = (state == ST_EXEC) && exec_done &&
                  ((kind == FCPD_K_RECAL) || (kind == FCPD_K_SEEK));
  wire sense_go = (state == ST_IDLE) && cmd_take && is_sense;
  always_ff @(posedge mclk) begin
    if (rst) begin
      present_cylinder       <= '{default: 8'h00};
      int_pend  <= 1'b0;
      int_st0   <= 8'h00;
      int_drive <= 2'h0;
    end else begin
      if (pos_done) begin
        present_cylinder[sel_drive] <= exec_cmd.cylinder;
        int_st0        <= `FCPD_ST0_SEEK_END | {5'h00, exec_cmd.head_select, sel_drive};
        int_drive      <= sel_drive;
      end
      // a completion in the same cycle as a sense keeps the interrupt set
      if (pos_done) begin
        int_pend <= 1'b1;
      end else if (sense_go) begin
        int_pend <= 1'b0;
      end
    end
  end
  assign done_irq = int_pend || (state == ST_RESULT && kind != FCPD_K_SENSE
                                 && kind != FCPD_K_INVALID);

  ////////////////////////////////////////////////////////////////////////////
  // specify and configure settings
  wire last_prm = (state == ST_PARAM) && cmd_take && (prm_idx == prm_need - 4'h1);
  always_ff @(posedge mclk) begin
    if (rst) begin
      setup <= '0;
    end else if (last_prm && kind == FCPD_K_SPECIFY) begin
      setup.step_rate_time    <= prm[0][7:4];
      setup.head_unload_time  <= prm[0][3:0];
      setup.head_load_time    <= cmd_data[7:1];
      setup.pio_transfer_flag <= cmd_data[0];
    end else if (last_prm && kind == FCPD_K_CONFIG) begin
      setup.implied_seek_enable    <= prm[1][6];
      setup.queue_disable          <= prm[1][5];
      setup.poll_disable           <= prm[1][4];
      setup.queue_threshold        <= prm[1][3:0];
      setup.precomp_start_cylinder <= cmd_data;
    end
  end
endmodule

// [verif/fcpd_top_asserts.sv]
// port checker for the floppy command phase decoder
`timescale 1ns/10ps
module fcpd_top_asserts
  import fcpd_pkg::*;
(
  // clock and reset
  input logic        mclk,
  input logic        rst,
  // host side
  input logic        cmd_valid,
  input logic [7:0]  cmd_data,
  input logic        cmd_ready,
  input logic        res_valid,
  input logic [7:0]  res_data,
  input logic        res_ready,
  // drive side and status
  input logic        exec_start,
  input logic        exec_done,
  input logic        done_irq,
  input fcpd_setup_t setup,
  input logic        busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // opcode taken while idle
  wire take_op = !busy && cmd_valid && cmd_ready;

  ////////////////////////////////////////////////////////////////////////////
  // reset and standby
  reset_idle_a: assert property (
    $past(rst) |-> !busy && !exec_start && !done_irq && setup == '0)
    else $error("port not idle after reset");
  idle_ready_a: assert property (
    !busy |-> cmd_ready && !res_valid)
    else $error("standby without ready");
  // execution start and completion
  start_pulse_a: assert property (
    exec_start |=> !exec_start)
    else $error("start pulse too long");
  start_after_take_a: assert property (
    exec_start |-> busy && !res_valid && $past(cmd_valid && cmd_ready))
    else $error("start without last parameter");
  done_irq_a: assert property (
    exec_done && busy && !res_valid |=> done_irq)
    else $error("completion raised no interrupt");
  // result phase
  result_hold_a: assert property (
    res_valid && !res_ready |=> res_valid && $stable(res_data))
    else $error("result byte not held");
  result_refuse_a: assert property (
    res_valid |-> !cmd_ready)
    else $error("byte accepted in result phase");
  sense_answer_a: assert property (
    take_op && cmd_data == 8'h08 |=> res_valid)
    else $error("sense gave no result");
  invalid_status_a: assert property (
    take_op && cmd_data == 8'h00 |=> res_valid && res_data == 8'h80)
    else $error("invalid opcode status wrong");
endmodule

bind fcpd_top fcpd_top_asserts fcpd_top_asserts_i (.mclk, .rst, .cmd_valid, .cmd_data,
  .cmd_ready, .res_valid, .res_data, .res_ready, .exec_start, .exec_done, .done_irq,
  .setup, .busy);

// [verif/fcpd_host_model.sv]
// host model writing and reading the controller data port
`timescale 1ns/10ps
module fcpd_host_model (
  // clock
  input  logic       mclk,
  // command bytes
  output logic       cmd_valid,
  output logic [7:0] cmd_data,
  input  logic       cmd_ready,
  // result bytes
  input  logic       res_valid,
  input  logic [7:0] res_data,
  output logic       res_ready
);
  // handshakes that never completed within the wait limit
  int stuck;
  // port quiet at start
  initial begin
    stuck     = 0;
    cmd_valid = 1'b0;
    cmd_data  = 8'hFF;
    res_ready = 1'b0;
  end
  // one step past the edge
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // offer one byte and hold it until taken, whether opcode, parameter or data byte
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    if (!cmd_valid) cmd_valid = 1'b1;
    cmd_data = b;
    while (cmd_ready !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    if (n == 400) stuck++;
    tick();
  endtask
  // release the byte lane, data no longer valid
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_data  = ~cmd_data;
  endtask
  // read one result byte
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    res_ready = 1'b1;
    while (res_valid !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    if (n == 400) stuck++;
    b = res_data;
    tick();
  endtask
  // stop reading
  task automatic rel();
    res_ready = 1'b0;
  endtask
endmodule

// [verif/fcpd_top_tb.sv]
// self-checking bench for the floppy command phase decoder
`timescale 1ns/10ps
module fcpd_top_tb;
  import fcpd_pkg::*;
  logic        mclk, rst, cmd_valid, cmd_ready, res_valid, res_ready;
  logic        exec_start, exec_done, drv_valid, drv_ready, done_irq, busy;
  logic [7:0]  cmd_data, res_data, drv_data;
  fcpd_exec_t  exec_cmd;
  fcpd_done_t  exec_report;
  fcpd_setup_t setup;
  logic [7:0]  drv_q[$];
  int          errors, total_checks;
  // report used by every completion: st0..st2, C, H, R, N
  localparam fcpd_done_t REP = {8'h01, 8'h02, 8'h03, 8'h11, 8'h01, 8'h04, 8'h02};

  fcpd_top #(.FIFO_DEPTH(32)) fcpd_top_i (.mclk, .rst, .cmd_valid, .cmd_data, .cmd_ready,
    .res_valid, .res_data, .res_ready, .exec_start, .exec_cmd, .exec_done, .exec_report,
    .drv_valid, .drv_data, .drv_ready, .done_irq, .setup, .busy);
  fcpd_host_model fcpd_host_model_i (.mclk, .cmd_valid, .cmd_data, .cmd_ready,
    .res_valid, .res_data, .res_ready);

  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog and drive-side capture
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  always @(posedge mclk) if (drv_valid && drv_ready) drv_q.push_back(drv_data);

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic tick();
    fcpd_host_model_i.tick();
  endtask
  task automatic ps(input logic [7:0] q[$]);
    foreach (q[i]) fcpd_host_model_i.put(q[i]);
    fcpd_host_model_i.idle();
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input string nm, input logic [7:0] e);
    logic [7:0] v;
    fcpd_host_model_i.get(v);
    chk(nm, e, v);
  endtask
  // wait for the execution pulse
  task automatic go();
    int n;
    n = 0;
    while (exec_start !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk("exec_start", 8'h01, {7'h00, exec_start});
  endtask
  // drive side reports completion
  task automatic fin();
    tick();
    exec_report = REP;
    exec_done   = 1'b1;
    tick();
    exec_done   = 1'b0;
  endtask
  task automatic sense(input logic [7:0] st0, input logic [7:0] present_cylinder);
    ps('{8'h08});
    rd("sense st0", st0);
    rd("sense pcn", present_cylinder);
    fcpd_host_model_i.rel();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_position();
    ps('{8'h0F, 8'h01, 8'h2A});
    go();
    chk("seek kind", 8'(FCPD_K_SEEK), 8'(exec_cmd.kind));
    chk("seek cyl", 8'h2A, exec_cmd.cylinder);
    fin();
    chk("seek irq", 8'h01, {7'h00, done_irq});
    sense(8'h21, 8'h2A);
    chk("irq cleared", 8'h00, {7'h00, done_irq});
    ps('{8'h07, 8'h02});
    go();
    chk("recal kind", 8'(FCPD_K_RECAL), 8'(exec_cmd.kind));
    chk("recal drive", 8'h02, 8'(exec_cmd.drive_select));
    chk("recal cyl", 8'h00, exec_cmd.cylinder);
    fin();
    sense(8'h22, 8'h00);
    sense(8'h80, 8'h00);
  endtask
  task automatic t_write(input logic [7:0] op, input fcpd_kind_t k, input int n,
                         input logic stall);
    ps('{op, 8'h05, 8'h11, 8'h01, 8'h03, 8'h02, 8'h09, 8'h1B, 8'hFF});
    go();
    chk("write kind", 8'(k), 8'(exec_cmd.kind));
    chk("flags", {6'h00, op[7:6]}, {6'h00, exec_cmd.multi_track, exec_cmd.double_density});
    chk("drive", 8'h05, {5'h00, exec_cmd.head_select, exec_cmd.drive_select});
    chk("record", 8'h03, exec_cmd.record);
    chk("cylinder", 8'h11, exec_cmd.cylinder);
    chk("gap length", 8'h1B, exec_cmd.gap_length);
    chk("data length", 8'hFF, exec_cmd.data_length);
    drv_q.delete();
    drv_ready = !stall;
    for (int i = 0; i < n; i++) fcpd_host_model_i.put(8'(8'hA0 + i));
    fcpd_host_model_i.idle();
    tick();
    if (stall) chk("full refuses", 8'h00, {7'h00, cmd_ready});
    drv_ready = 1'b1;
    repeat (n + 8) tick();
    chk("drive count", 8'(n), 8'(drv_q.size()));
    foreach (drv_q[i]) chk("drive data", 8'(8'hA0 + i), drv_q[i]);
    fin();
    chk("write irq", 8'h01, {7'h00, done_irq});
    for (int i = 0; i < 7; i++) rd("write result", REP[55-8*i -: 8]);
    fcpd_host_model_i.rel();
  endtask
  task automatic t_format();
    ps('{8'h4D, 8'h00, 8'h02, 8'h01, 8'h1B, 8'hE5});
    go();
    chk("format kind", 8'(FCPD_K_FORMAT), 8'(exec_cmd.kind));
    chk("format spt", 8'h01, exec_cmd.sectors_per_track);
    chk("filler", 8'hE5, exec_cmd.filler);
    chk("format size", 8'h02, exec_cmd.size_code);
    chk("format gap", 8'h1B, exec_cmd.gap_length);
    ps('{8'h00, 8'h00, 8'h01, 8'h02});
    tick();
    chk("ids refused", 8'h00, {7'h00, cmd_ready});
    fin();
    for (int i = 0; i < 3; i++) rd("format status", REP[55-8*i -: 8]);
    repeat (4) rd("format tail", 8'h00);
    fcpd_host_model_i.rel();
  endtask
  task automatic t_setup();
    ps('{8'h03, 8'hA5, 8'h0B});
    ps('{8'h13, 8'h00, 8'h57, 8'h10});
    repeat (2) tick();
    chk("step/unload", 8'hA5, {setup.step_rate_time, setup.head_unload_time});
    chk("load/pio", 8'h0B, {setup.head_load_time, setup.pio_transfer_flag});
    chk("options", 8'h57, {1'b0, setup.implied_seek_enable, setup.queue_disable,
        setup.poll_disable, setup.queue_threshold});
    chk("precomp", 8'h10, setup.precomp_start_cylinder);
    chk("no results", 8'h00, {6'h00, res_valid, busy});
  endtask
  task automatic t_invalid();
    ps('{8'h00});
    rd("invalid st0", 8'h80);
    ps('{8'h1F});
    rd("invalid st0", 8'h80);
    fcpd_host_model_i.rel();
    tick();
    chk("standby", 8'h00, {7'h00, busy});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and main sequence
  task automatic report_and_stop();
    errors = errors + fcpd_host_model_i.stuck;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst          = 1'b1;
    exec_done    = 1'b0;
    exec_report  = '0;
    drv_ready    = 1'b1;
    errors       = 0;
    total_checks = 0;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("ready after reset", 8'h01, {7'h00, cmd_ready});
    t_position();
    t_write(8'hC5, FCPD_K_WRITE, 32, 1'b1);
    t_write(8'h49, FCPD_K_WDEL, 3, 1'b0);
    t_format();
    t_setup();
    t_invalid();
    report_and_stop();
  end
endmodule
